// ==== rtl/sfe_defs.vh ====
// Purpose: Shared constants of the serial flash wipe-command block.
// Assumes: 50 MHz system clock; 32M-byte array (25 address bits).
// Notes:   Opcodes and wipe times are plain defaults; edit here only.
`ifndef SFE_DEFS_VH
`define SFE_DEFS_VH
// ==========================================================
// Command opcodes
`define SFE_OP_WRITE_UNLOCK 8'h06
`define SFE_OP_WIPE_4K 8'h20
`define SFE_OP_WIPE_32K 8'h52
`define SFE_OP_WIPE_64K 8'hD8
`define SFE_OP_WIPE_CHIP 8'hC7
`define SFE_OP_WIPE_CHIP_ALT 8'h60
// ==========================================================
// Array geometry
`define SFE_AW 25
`define SFE_BLK_W 9
`define SFE_BLK_TOP 9'h1FF
`define SFE_BLK_BOTTOM 9'h000
`define SFE_BLK_COUNT 10'h200
`define SFE_SEC_LSB 12
`define SFE_HALF_LSB 15
`define SFE_BLK_LSB 16
// ==========================================================
// Frame bit counts (opcode, opcode plus 3 or 4 address bytes)
`define SFE_CNT_W 6
`define SFE_BITS_OPC 6'h08
`define SFE_BITS_3B 6'h20
`define SFE_BITS_4B 6'h28
`define SFE_BITS_SAT 6'h30
// ==========================================================
// Wipe kinds reported to the array
`define SFE_KIND_4K 2'h0
`define SFE_KIND_32K 2'h1
`define SFE_KIND_64K 2'h2
`define SFE_KIND_CHIP 2'h3
// Protect level at and above which the whole array is locked
`define SFE_BP_ALL 4'hA
// ==========================================================
// Timing: figures in microseconds, clock in MHz
`define SFE_CLK_MHZ 32'd50
`define SFE_T_SECTOR_WIPE_US 32'd30000
`define SFE_T_HALF_BLOCK_WIPE_US 32'd150000
`define SFE_T_BLOCK_WIPE_US 32'd300000
`define SFE_T_WHOLE_WIPE_US 32'd60000000
`endif

// ==== rtl/sfe_erase_top.v ====
// Purpose: Wipe-command handling of a serial NOR flash (4K/32K/64K/chip).
// Assumes: Host link is slow against clk_in; all host link pins are resynchronised.
// Notes:   Data sampled on serial clock rise (mode 0); array acts on pulses.
`timescale 1ns/1ps
`include "sfe_defs.vh"
module sfe_erase_top #(
    parameter [31:0] T_SECTOR_WIPE_CYC = `SFE_T_SECTOR_WIPE_US * `SFE_CLK_MHZ,
    parameter [31:0] T_HALF_BLOCK_WIPE_CYC = `SFE_T_HALF_BLOCK_WIPE_US * `SFE_CLK_MHZ,
    parameter [31:0] T_BLOCK_WIPE_CYC = `SFE_T_BLOCK_WIPE_US * `SFE_CLK_MHZ,
    parameter [31:0] T_WHOLE_WIPE_CYC = `SFE_T_WHOLE_WIPE_US * `SFE_CLK_MHZ
) (
    input wire clk_in,
    input wire nrst_in,
    input wire chip_sel_n_in,
    input wire serial_clk_in,
    input wire [3:0] sio_lines_in,
    input wire quad_cmd_mode_in,
    input wire wide_addr_mode_in,
    input wire upper_addr_bits_in,
    input wire [3:0] protect_level_bits_in,
    input wire protect_scheme_select_in,
    input wire lock_block_in,
    input wire [15:0] top_sector_lock_in,
    input wire [15:0] bottom_sector_lock_in,
    output wire busy_flag_out,
    output wire write_unlock_flag_out,
    output wire [8:0] lock_query_blk_out,
    output wire array_wipe_out,
    output wire [1:0] array_wipe_kind_out,
    output wire [24:0] array_wipe_addr_out,
    output wire cmd_reject_out
);
    // ==========================================================
    // State codes
    localparam [1:0] ST_IDLE = 2'b00; // Waiting for a command
    localparam [1:0] ST_WALK = 2'b01; // Stepping blocks of a chip wipe
    localparam [1:0] ST_WAIT = 2'b10; // Self-timed wipe running

    // ==========================================================
    // Pin synchronisation and edge finding
    wire [5:0] pins_s; // Synced {sio[3:0], sclk, ~cs_n}
    reg sclk_d_q; // Previous synced serial clock
    reg cs_d_q; // Previous synced select

    sfe_sync2 #(
        .W(6)
    ) u_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .async_in({sio_lines_in, serial_clk_in, ~chip_sel_n_in}),
        .sync_out(pins_s)
    );

    wire cs_n_s = ~pins_s[0]; // Reset reads deselected
    wire sclk_s = pins_s[1]; // Serial clock
    wire [3:0] sio_s = pins_s[5:2]; // Data lines
    wire sclk_rise = sclk_s & ~sclk_d_q; // Sample point
    wire cs_rise = cs_n_s & ~cs_d_q; // Frame end
    wire cs_fall = ~cs_n_s & cs_d_q; // Frame start

    // Edge history flops
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sclk_d_q <= 1'b0;
            cs_d_q <= 1'b1;
        end else begin
            sclk_d_q <= sclk_s;
            cs_d_q <= cs_n_s;
        end
    end

    // ==========================================================
    // Frame shifter
    reg [39:0] shift_q; // Opcode and address bits, newest in low end
    reg [5:0] bit_cnt_q; // Bits taken this frame, saturating
    reg [7:0] opcode_q; // Opcode once eight bits are in

    // Shift and count on each serial clock rise
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            shift_q <= 40'h00_0000_0000;
            bit_cnt_q <= 6'h00;
            opcode_q <= 8'h00;
        end else if (cs_fall) begin
            // New frame clears the count
            bit_cnt_q <= 6'h00;
            opcode_q <= 8'h00;
        end else if (sclk_rise && !cs_n_s) begin
            if (quad_cmd_mode_in) begin
                // Quad: four bits a clock, opcode in two clocks
                shift_q <= {shift_q[35:0], sio_s};
                if (bit_cnt_q < `SFE_BITS_SAT) begin
                    bit_cnt_q <= bit_cnt_q + 6'h04;
                end
                if (bit_cnt_q == 6'h04) begin
                    opcode_q <= {shift_q[3:0], sio_s};
                end
            end else begin
                // Single line: upper lines are ignored
                shift_q <= {shift_q[38:0], sio_s[0]};
                if (bit_cnt_q < `SFE_BITS_SAT) begin
                    bit_cnt_q <= bit_cnt_q + 6'h01;
                end
                if (bit_cnt_q == 6'h07) begin
                    opcode_q <= {shift_q[6:0], sio_s[0]};
                end
            end
        end
    end

    // ==========================================================
    // Command decode at frame end
    wire op_4k = (opcode_q == `SFE_OP_WIPE_4K);
    wire op_32k = (opcode_q == `SFE_OP_WIPE_32K);
    wire op_64k = (opcode_q == `SFE_OP_WIPE_64K);
    wire op_chip = (opcode_q == `SFE_OP_WIPE_CHIP) || (opcode_q == `SFE_OP_WIPE_CHIP_ALT);
    wire op_unlock = (opcode_q == `SFE_OP_WRITE_UNLOCK);
    wire op_addr = op_4k | op_32k | op_64k; // Address-bearing wipes
    wire op_wipe = op_addr | op_chip;

    // Exact length wanted: opcode plus three or four address bytes
    wire [5:0] need_bits = wide_addr_mode_in ? `SFE_BITS_4B : `SFE_BITS_3B;
    wire frame_ok = op_addr ? (bit_cnt_q == need_bits)
                            : (bit_cnt_q == `SFE_BITS_OPC);

    // Upper bit from wide address or from the upper address setting
    wire [24:0] tgt_addr = wide_addr_mode_in ? shift_q[24:0]
                                             : {upper_addr_bits_in, shift_q[23:0]};
    wire [8:0] tgt_blk = tgt_addr[24:`SFE_BLK_LSB];
    wire [3:0] tgt_sec = tgt_addr[15:`SFE_SEC_LSB];
    wire tgt_upper_half = tgt_addr[`SFE_HALF_LSB];

    // ==========================================================
    // Protection checks
    reg [1:0] state_q; // Sequencer state
    reg [8:0] qblk_q; // Block under lock query / walk index
    wire [9:0] bp_thr = `SFE_BLK_COUNT -
                        (10'h001 << (protect_level_bits_in - 4'h1)); // First locked block
    wire bp_any = (protect_level_bits_in != 4'h0);
    wire bp_locked = bp_any && ((protect_level_bits_in >= `SFE_BP_ALL) ||
                                ({1'b0, tgt_blk} >= bp_thr)); // Level scheme, top down

    // Sector locks of the edge block that holds the target, if any
    wire is_top = (tgt_blk == `SFE_BLK_TOP);
    wire is_bot = (tgt_blk == `SFE_BLK_BOTTOM);
    wire [15:0] edge_locks = is_top ? top_sector_lock_in :
                             (is_bot ? bottom_sector_lock_in : 16'h0000);
    wire [7:0] half_locks = tgt_upper_half ? edge_locks[15:8] : edge_locks[7:0];
    wire edge_blk = is_top | is_bot;

    // Individual scheme: lock answer for qblk_q, which tracks tgt_blk while idle
    reg indiv_locked; // Target locked under individual scheme
    always @* begin
        indiv_locked = lock_block_in;
        if (edge_blk) begin
            if (op_4k) begin
                indiv_locked = edge_locks[tgt_sec];
            end else if (op_32k) begin
                indiv_locked = lock_block_in | (|half_locks);
            end else begin
                indiv_locked = lock_block_in | (|edge_locks);
            end
        end
    end

    // Chip wipe refused in level scheme when any level is set
    wire prot_hit = op_chip ? (~protect_scheme_select_in & bp_any)
                            : (protect_scheme_select_in ? indiv_locked
                                                        : bp_locked);

    // ==========================================================
    // Acceptance
    reg busy_q; // Busy flag
    reg unlock_q; // Write unlock flag
    wire frame_end = cs_rise;
    wire accept = frame_end && op_wipe && frame_ok && unlock_q
                  && !busy_q && !prot_hit;
    wire unlock_set = frame_end && op_unlock && (bit_cnt_q == `SFE_BITS_OPC);

    // ==========================================================
    // Walk lock answer for the current walk block
    wire walk_top = (qblk_q == `SFE_BLK_TOP);
    wire walk_bot = (qblk_q == `SFE_BLK_BOTTOM);
    wire walk_skip = lock_block_in | (walk_top & (|top_sector_lock_in))
                     | (walk_bot & (|bottom_sector_lock_in));

    // ==========================================================
    // Timer
    reg tmr_start_q; // One-cycle start pulse
    reg [31:0] tmr_load_q; // Duration for the running wipe
    wire tmr_done;
    sfe_wipe_timer u_timer (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .start_in(tmr_start_q),
        .load_in(tmr_load_q),
        .run_out(),
        .done_out(tmr_done)
    );

    // Duration by kind
    reg [31:0] dur_sel; // Duration of the decoded kind
    reg [1:0] kind_sel; // Kind of the decoded command
    always @* begin
        if (op_4k) begin
            dur_sel = T_SECTOR_WIPE_CYC;
            kind_sel = `SFE_KIND_4K;
        end else if (op_32k) begin
            dur_sel = T_HALF_BLOCK_WIPE_CYC;
            kind_sel = `SFE_KIND_32K;
        end else if (op_64k) begin
            dur_sel = T_BLOCK_WIPE_CYC;
            kind_sel = `SFE_KIND_64K;
        end else begin
            dur_sel = T_WHOLE_WIPE_CYC;
            kind_sel = `SFE_KIND_CHIP;
        end
    end

    // Aligned base address of the region to wipe
    reg [24:0] base_sel; // Region base
    always @* begin
        if (op_4k) begin
            base_sel = {tgt_addr[24:`SFE_SEC_LSB], 12'h000};
        end else if (op_32k) begin
            base_sel = {tgt_addr[24:`SFE_HALF_LSB], 15'h0000};
        end else if (op_64k) begin
            base_sel = {tgt_addr[24:`SFE_BLK_LSB], 16'h0000};
        end else begin
            base_sel = 25'h000_0000;
        end
    end

    // ==========================================================
    // Sequencer, flags and array pulses
    reg wipe_q; // Array wipe pulse
    reg [1:0] kind_q; // Kind of that pulse
    reg [24:0] addr_q; // Base of that pulse
    reg reject_q; // Refused wipe pulse

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_IDLE;
            qblk_q <= 9'h000;
            busy_q <= 1'b0;
            unlock_q <= 1'b0;
            wipe_q <= 1'b0;
            kind_q <= `SFE_KIND_4K;
            addr_q <= 25'h000_0000;
            reject_q <= 1'b0;
            tmr_start_q <= 1'b0;
            tmr_load_q <= 32'h0000_0000;
        end else begin
            wipe_q <= 1'b0;
            tmr_start_q <= 1'b0;
            reject_q <= frame_end && op_wipe && !accept;
            // Unlock set wins over a same-cycle end-of-wipe clear
            if (unlock_set) begin
                unlock_q <= 1'b1;
            end else if (tmr_done && state_q == ST_WAIT) begin
                unlock_q <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    qblk_q <= tgt_blk;
                    if (accept) begin
                        busy_q <= 1'b1;
                        tmr_load_q <= dur_sel;
                        if (op_chip && protect_scheme_select_in) begin
                            // Per-block walk, locked blocks skipped
                            qblk_q <= 9'h000;
                            state_q <= ST_WALK;
                        end else begin
                            wipe_q <= 1'b1;
                            kind_q <= kind_sel;
                            addr_q <= base_sel;
                            tmr_start_q <= 1'b1;
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WALK: begin
                    if (!walk_skip) begin
                        wipe_q <= 1'b1;
                        kind_q <= `SFE_KIND_64K;
                        addr_q <= {qblk_q, 16'h0000};
                    end
                    qblk_q <= qblk_q + 9'h001;
                    if (qblk_q == `SFE_BLK_TOP) begin
                        tmr_start_q <= 1'b1;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (tmr_done) begin
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Outputs, all from flops
    assign busy_flag_out = busy_q;
    assign write_unlock_flag_out = unlock_q;
    assign lock_query_blk_out = qblk_q;
    assign array_wipe_out = wipe_q;
    assign array_wipe_kind_out = kind_q;
    assign array_wipe_addr_out = addr_q;
    assign cmd_reject_out = reject_q;
endmodule

// ==== rtl/sfe_sync2.v ====
// Purpose: Two-flop synchroniser for pins entering the clk_in domain.
// Assumes: Each bit is an independent level.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module sfe_sync2 #(
    parameter W = 6
) (
    input wire clk_in,
    input wire nrst_in,
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    // ==========================================================
    // Per-bit double flop
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_q; // First stage, read only by stage two
            reg safe_q; // Second stage, safe to use
            always @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    meta_q <= 1'b0;
                    safe_q <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    safe_q <= meta_q;
                end
            end
            assign sync_out[i] = safe_q;
        end
    endgenerate
endmodule

// ==== rtl/sfe_wipe_timer.v ====
// Purpose: Self-timed wipe duration counter.
// Assumes: load_in is at least one cycle.
// Notes:   done_out is a one-cycle pulse at the end of the count.
`timescale 1ns/1ps
module sfe_wipe_timer (
    input wire clk_in,
    input wire nrst_in,
    input wire start_in,
    input wire [31:0] load_in,
    output wire run_out,
    output wire done_out
);
    reg [31:0] cnt_q; // Cycles remaining
    reg run_q; // Counting
    reg done_q; // End pulse

    // ==========================================================
    // Down counter
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q <= 32'h0000_0000;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start_in) begin
                // Zero load still lasts one cycle
                cnt_q <= (load_in == 32'h0000_0000) ? 32'h0000_0001 : load_in;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (cnt_q == 32'h0000_0001) begin
                    run_q <= 1'b0;
                    done_q <= 1'b1;
                end
                cnt_q <= cnt_q - 32'h0000_0001;
            end
        end
    end

    assign run_out = run_q;
    assign done_out = done_q;
endmodule

// ==== verif/sfe_erase_properties.sv ====
// Purpose: Port-level properties of the wipe-command block.
// Assumes: Protection inputs are steady around a wipe pulse.
// Notes:   Bound to the top module from the bench top file.
`timescale 1ns/1ps
`include "sfe_defs.vh"
module sfe_erase_properties (
    input wire clk_in,
    input wire nrst_in,
    input wire chip_sel_n_in,
    input wire [3:0] protect_level_bits_in,
    input wire protect_scheme_select_in,
    input wire lock_block_in,
    input wire busy_flag_out,
    input wire write_unlock_flag_out,
    input wire array_wipe_out,
    input wire [1:0] array_wipe_kind_out,
    input wire [24:0] array_wipe_addr_out,
    input wire cmd_reject_out
);
    // ==========================================
    // One clock domain
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    // Pulse kind shorthands
    wire w4k = array_wipe_out && array_wipe_kind_out == `SFE_KIND_4K;
    wire w32k = array_wipe_out && array_wipe_kind_out == `SFE_KIND_32K;
    wire w64k = array_wipe_out && array_wipe_kind_out == `SFE_KIND_64K;
    wire wchip = array_wipe_out && array_wipe_kind_out == `SFE_KIND_CHIP;
    // ==========================================
    // Start and busy window
    a_wipe_marks_busy: assert property (array_wipe_out |-> busy_flag_out)
        else $error("wipe pulse without busy");
    a_start_after_cs: assert property (array_wipe_out && !$past(busy_flag_out) |->
        $past(chip_sel_n_in, 2) && $past(chip_sel_n_in, 3)) else $error("start without deselect");
    a_start_unlocked: assert property ($rose(busy_flag_out) |-> $past(write_unlock_flag_out))
        else $error("wipe without unlock");
    a_end_clears_unlock: assert property ($fell(busy_flag_out) |-> !write_unlock_flag_out)
        else $error("unlock left set");
    a_busy_min_len: assert property ($rose(busy_flag_out) |-> busy_flag_out[*8])
        else $error("busy dropped early");
    a_busy_bounded: assert property ($rose(busy_flag_out) |-> ##[1:1000] !busy_flag_out)
        else $error("busy never ends");
    // ==========================================
    // Region alignment and protection
    a_sector_base: assert property (w4k |-> array_wipe_addr_out[11:0] == 12'h000)
        else $error("sector base");
    a_half_base: assert property (w32k |-> array_wipe_addr_out[14:0] == 15'h0000)
        else $error("half base");
    a_block_base: assert property (w64k |-> array_wipe_addr_out[15:0] == 16'h0000)
        else $error("block base");
    a_chip_levels: assert property (wchip |-> !protect_scheme_select_in &&
        protect_level_bits_in == 4'h0) else $error("chip wipe protected");
    a_walk_skips_locked: assert property (array_wipe_out && protect_scheme_select_in |->
        !$past(lock_block_in)) else $error("locked block wiped");
    a_no_overlap: assert property (array_wipe_out && $past(busy_flag_out) |->
        protect_scheme_select_in && w64k) else $error("wipe while busy");
    // Main scenarios reached
    cover property (wchip);
    cover property (cmd_reject_out && busy_flag_out);
    cover property (w64k && protect_scheme_select_in && $past(busy_flag_out));
endmodule

// ==== verif/sfe_host_model.sv ====
// Purpose: Host link driver standing in for the flash controller.
// Assumes: Moves only at falling edges of the bench clock.
// Notes:   Idle data lines show the inverse of the last value.
`timescale 1ns/1ps
module sfe_host_model (
    input wire clk_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic [3:0] sio_out
);
    // Half of the 160 ns link period, in bench clocks
    localparam int HALF = 4;
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sio_out = 4'h5;
    end
    // One frame: n bits of v from the top, a nibble per clock in quad
    task automatic send(input logic [39:0] v, input int n, input logic quad);
        int k;
        k = 0;
        cs_n_out = 1'b0;
        repeat (HALF) @(negedge clk_in);
        while (k < n) begin
            // Upper lines carry noise in single mode
            sio_out = quad ? v[39:36] : {3'($urandom), v[39]};
            v = quad ? v << 4 : v << 1;
            k += quad ? 4 : 1;
            repeat (HALF) @(negedge clk_in);
            sclk_out = 1'b1;
            repeat (HALF) @(negedge clk_in);
            sclk_out = 1'b0;
        end
        repeat (HALF) @(negedge clk_in);
        // Deselect with clock low; released lines must not hold data
        cs_n_out = 1'b1;
        sio_out = ~sio_out;
        repeat (2 * HALF) @(negedge clk_in);
    endtask
endmodule

// ==== verif/tb_sfe_erase_top.sv ====
// Purpose: Self-checking bench for the wipe-command block.
// Assumes: Protection inputs change only between frames.
// Notes:   Wipe times shortened by parameter to keep the run brief.
`timescale 1ns/1ps
`include "sfe_defs.vh"
module tb_sfe_erase_top;
    // ==========================================
    // Bench-driven inputs and observed outputs
    logic clk_in, nrst_in, quad_cmd_mode_in, wide_addr_mode_in, upper_addr_bits_in;
    logic protect_scheme_select_in, lock_block_in, lock_on;
    logic [3:0] protect_level_bits_in;
    logic [15:0] top_sector_lock_in, bottom_sector_lock_in;
    wire chip_sel_n_in, serial_clk_in, busy_flag_out, write_unlock_flag_out;
    wire array_wipe_out, cmd_reject_out;
    wire [3:0] sio_lines_in;
    wire [8:0] lock_query_blk_out;
    wire [1:0] array_wipe_kind_out;
    wire [24:0] array_wipe_addr_out;
    logic [27:0] notes[$]; // Expected {reject, kind, base}, oldest first
    int err_total, cmp_count, i;
    sfe_host_model sfe_host_model_i (.clk_in, .cs_n_out(chip_sel_n_in),
        .sclk_out(serial_clk_in), .sio_out(sio_lines_in));
    // Short wipe times; chip time outlasts two quad frames
    sfe_erase_top #(.T_SECTOR_WIPE_CYC(32'd40), .T_HALF_BLOCK_WIPE_CYC(32'd60),
        .T_BLOCK_WIPE_CYC(32'd80), .T_WHOLE_WIPE_CYC(32'd300)) sfe_erase_top_i (
        .clk_in, .nrst_in, .chip_sel_n_in, .serial_clk_in, .sio_lines_in, .quad_cmd_mode_in,
        .wide_addr_mode_in, .upper_addr_bits_in, .protect_level_bits_in, .lock_block_in,
        .protect_scheme_select_in, .top_sector_lock_in, .bottom_sector_lock_in, .busy_flag_out,
        .write_unlock_flag_out, .lock_query_blk_out, .array_wipe_out, .array_wipe_kind_out,
        .array_wipe_addr_out, .cmd_reject_out);
    // ==========================================
    // Clock, lock answer and watchdog
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // Odd blocks locked, top block left to its sector locks
    always @(negedge clk_in) begin
        lock_block_in <= lock_on & lock_query_blk_out[0] & ~&lock_query_blk_out;
    end
    // Far past a run of some 8k cycles
    initial begin
        #2000000;
        err_total++;
        wrap_up();
    end
    // ==========================================
    // Checking and verdict
    task automatic check(input logic [27:0] seen, input logic [27:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Every pulse or refusal takes the oldest note
    always @(negedge clk_in) begin
        if (array_wipe_out === 1'b1 || cmd_reject_out === 1'b1) begin
            check(cmd_reject_out ? {1'b1, 27'h0} : {1'b0, array_wipe_kind_out,
                array_wipe_addr_out}, notes.size() ? notes.pop_front() : 28'hFFFFFFF);
        end
    end
    // ==========================================
    // Frame tasks
    task automatic unlock();
        sfe_host_model_i.send({`SFE_OP_WRITE_UNLOCK, 32'h0}, 8, quad_cmd_mode_in);
    endtask
    task automatic chip(input int n, input logic rej);
        notes.push_back(rej ? {1'b1, 27'h0} : {1'b0, `SFE_KIND_CHIP, 25'h0});
        sfe_host_model_i.send({`SFE_OP_WIPE_CHIP, 32'h0}, n, quad_cmd_mode_in);
    endtask
    task automatic wipe(input logic [1:0] kind, input logic [31:0] a, input logic rej);
        logic [24:0] base;
        logic [7:0] op;
        base = wide_addr_mode_in ? a[24:0] : {upper_addr_bits_in, a[23:0]};
        case (kind)
            `SFE_KIND_4K: begin
                op = `SFE_OP_WIPE_4K;
                base[11:0] = 12'h000;
            end
            `SFE_KIND_32K: begin
                op = `SFE_OP_WIPE_32K;
                base[14:0] = 15'h0000;
            end
            default: begin
                op = `SFE_OP_WIPE_64K;
                base[15:0] = 16'h0000;
            end
        endcase
        notes.push_back(rej ? {1'b1, 27'h0} : {1'b0, kind, base});
        sfe_host_model_i.send(wide_addr_mode_in ? {op, a} : {op, a[23:0], 8'h00},
            wide_addr_mode_in ? 40 : 32, quad_cmd_mode_in);
    endtask
    // Bounded wait for the end of a wipe
    task automatic idle();
        int k;
        k = 0;
        while (busy_flag_out !== 1'b0 && k < 2000) begin
            @(negedge clk_in);
            k++;
        end
        repeat (8) @(negedge clk_in);
        check({26'h0, busy_flag_out, write_unlock_flag_out}, 28'h0);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'h1e7b));
        nrst_in = 1'b0;
        {quad_cmd_mode_in, wide_addr_mode_in, upper_addr_bits_in, lock_on} = 4'h0;
        {protect_scheme_select_in, protect_level_bits_in} = 5'h00;
        {top_sector_lock_in, bottom_sector_lock_in} = 32'h0000_0000;
        repeat (12) @(negedge clk_in);
        nrst_in = 1'b1;
        repeat (6) @(negedge clk_in);
        // Each size in both command modes and both address widths
        for (i = 0; i < 12; i++) begin
            quad_cmd_mode_in = i[0];
            wide_addr_mode_in = i[1];
            upper_addr_bits_in = 1'($urandom);
            unlock();
            wipe(2'(i % 3), $urandom, 1'b0);
            idle();
        end
        quad_cmd_mode_in = 1'b0;
        wipe(`SFE_KIND_4K, $urandom, 1'b1);
        unlock();
        // One bit short, then one bit past the opcode: both refused
        notes.push_back({1'b1, 27'h0});
        sfe_host_model_i.send({`SFE_OP_WIPE_4K, 32'h0}, 39, 1'b0);
        chip(9, 1'b1);
        chip(8, 1'b0);
        // Inside the chip wipe: unlock taken, new wipe refused
        quad_cmd_mode_in = 1'b1;
        unlock();
        wipe(`SFE_KIND_4K, $urandom, 1'b1);
        quad_cmd_mode_in = 1'b0;
        idle();
        // Level scheme guarding the top block only
        protect_level_bits_in = 4'h1;
        wide_addr_mode_in = 1'b0;
        upper_addr_bits_in = 1'b1;
        unlock();
        wipe(`SFE_KIND_64K, 32'h00FF1234, 1'b1);
        wipe(`SFE_KIND_4K, 32'h00FFF000, 1'b1);
        chip(8, 1'b1);
        upper_addr_bits_in = 1'b0;
        wipe(`SFE_KIND_32K, 32'h00001234, 1'b0);
        idle();
        // Individual scheme; levels no longer count
        protect_level_bits_in = 4'hF;
        protect_scheme_select_in = 1'b1;
        lock_on = 1'b1;
        bottom_sector_lock_in = 16'h0010;
        top_sector_lock_in = 16'($urandom) | 16'h8000;
        unlock();
        wipe(`SFE_KIND_64K, 32'h00030000, 1'b1);
        wipe(`SFE_KIND_4K, 32'h00004000, 1'b1);
        wipe(`SFE_KIND_4K, 32'h00000123, 1'b0);
        idle();
        unlock();
        // End blocks skipped for their sector locks, odd ones for block locks
        for (i = 2; i < 511; i += 2) begin
            notes.push_back({1'b0, `SFE_KIND_64K, 9'(i), 16'h0000});
        end
        sfe_host_model_i.send({`SFE_OP_WIPE_CHIP_ALT, 32'h0}, 8, 1'b0);
        idle();
        check(28'(notes.size()), 28'h0);
        wrap_up();
    end
endmodule
bind sfe_erase_top sfe_erase_properties sfe_erase_properties_i (.clk_in, .nrst_in,
    .chip_sel_n_in, .protect_level_bits_in, .lock_block_in, .protect_scheme_select_in,
    .busy_flag_out, .write_unlock_flag_out, .array_wipe_out, .array_wipe_kind_out,
    .array_wipe_addr_out, .cmd_reject_out);
